/* File: design/ccp_pkg.sv */
// Constants of the compare and PWM unit
package ccp_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] OFF_UNIT_CONTROL = 8'h00;
    localparam logic [7:0] OFF_COMPARE_LOW = 8'h04;
    localparam logic [7:0] OFF_COMPARE_HIGH = 8'h08;
    localparam logic [7:0] OFF_PWM_PERIOD = 8'h0C;
    localparam logic [7:0] OFF_PERIOD_CONTROL = 8'h10;
    localparam logic [7:0] OFF_PERIOD_COUNT = 8'h14;
    localparam logic [7:0] OFF_ALT_PIN_SELECT = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;

    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic [5:0] RST_PRESC = 6'h00;
    localparam logic [9:0] RST_DUTY = 10'h000;

    // Fields of unit_control
    localparam int MODE_LSB = 0;
    localparam int DUTY_LOW_LSB = 4;
    localparam int OUT_CFG_LSB = 6;

    // Codes of mode_field
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_SET_ON_MATCH = 4'h8;
    localparam logic [3:0] MODE_CLEAR_ON_MATCH = 4'h9;
    localparam logic [3:0] MODE_SOFT_INT = 4'hA;
    localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;
    localparam logic [1:0] MODE_PWM_TOP = 2'h3;

    // Fields of period_timer_control
    localparam int PT_ON_BIT = 2;
    localparam int PT_PRESC_LSB = 0;
    localparam logic [1:0] PRESC_DIV1 = 2'h0;
    localparam logic [1:0] PRESC_DIV4 = 2'h1;

    // Prescaler wrap values: four system clocks per count, times the prescale
    localparam logic [5:0] PRESC_TOP_DIV1 = 6'h03;
    localparam logic [5:0] PRESC_TOP_DIV4 = 6'h0F;
    localparam logic [5:0] PRESC_TOP_DIV16 = 6'h3F;

    // Status bit positions
    localparam int STAT_FLAG_BIT = 0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ccp_pkg

/* File: design/ccp_compare_pwm.sv */
// Compare and standard PWM output unit with an AXI4-Lite register slave
// Summary of operation
// - Zero control write forces compare latch low
// - Mode 1010 only flags, pin untouched
// - Mode 1011 resets timer, starts enabled ADC
// - Special event mode leaves pin alone
// - Trigger raised on the match itself
// - Timer clear at following timer tick
// - Compare pair acts as timer period
// - Match reset never sets overflow flag
// - Match removed before tick skips clear
// - No compare activity during sleep
// - Alternate pin select routes pin function
// - PWM up to 10 bits on pin
// - Period, duty set by named registers only
// - Zero control write in PWM releases pin
// - Compare pair checked against timer continuously
// - Match acts on pin, sets unit flag
// - Period match clears timer, sets pin unless duty is zero, latches duty
// - Pin cleared when time base equals duty
module ccp_compare_pwm #(
    parameter int ADDR_W = 8,
    parameter int PIN_COUNT = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] timer_count,
    input wire logic timer_tick,
    input wire logic adc_enable,
    input wire logic sleep_mode,
    output logic [PIN_COUNT-1:0] unit_output_pin_o,
    output logic [PIN_COUNT-1:0] unit_output_pin_oe,
    output logic special_trigger_q,
    output logic adc_start_q,
    output logic timer_clear_q,
    output logic unit_interrupt_flag_q
);
    // Word address hit, low two bits ignored
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
        reg_hit = (addr[7:2] == off[7:2]);
    endfunction : reg_hit

    logic [ADDR_W-1:0] aw_addr_q;
    logic aw_hold_q, w_lane0_q, w_hold_q, alternate_pin_select_q, cmp_latch_q, pwm_q, match_q, pend_q, rolled_q;
    logic [7:0] w_data_q, unit_control_q, compare_value_low_q, compare_value_high_q, pwm_period_register_q;
    logic [7:0] period_timer_control_q, period_timer_count_q;
    logic [5:0] presc_q, presc_top;
    logic [1:0] duty_latch_q, frac;
    logic wr_go, wr_mapped, pwm_mode, cmp_mode, pin_driven, match_now, match_rise, pt_inc, rollover;
    logic [3:0] mode_field;

    // Write strobe for one register, byte lane 0 only
    function automatic logic wr_to(input logic [7:0] off);
        wr_to = wr_go && w_lane0_q && reg_hit(aw_addr_q, off);
    endfunction : wr_to

    // A write happens once both halves are held
    always_comb begin
        wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
        wr_mapped = (aw_addr_q[ADDR_W-1:5] == '0);
    end

    // Write address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= '0;
            s_axi_awready <= 1'b0;
            w_hold_q <= 1'b0;
            w_data_q <= ccp_pkg::RST_BYTE;
            w_lane0_q <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_hold_q) begin
                s_axi_awready <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_lane0_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (!w_hold_q) begin
                s_axi_wready <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // Write response; unmapped space answers SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ccp_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? ccp_pkg::RESP_OKAY : ccp_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel, answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ccp_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= (s_axi_araddr[ADDR_W-1:5] == '0) ? ccp_pkg::RESP_OKAY : ccp_pkg::RESP_SLVERR;
            s_axi_rdata <= 32'h0000_0000;
            if (s_axi_araddr[ADDR_W-1:5] == '0) begin
                unique case (s_axi_araddr[4:2])
                    ccp_pkg::OFF_UNIT_CONTROL[4:2]: s_axi_rdata[7:0] <= unit_control_q;
                    ccp_pkg::OFF_COMPARE_LOW[4:2]: s_axi_rdata[7:0] <= compare_value_low_q;
                    ccp_pkg::OFF_COMPARE_HIGH[4:2]: s_axi_rdata[7:0] <= compare_value_high_q;
                    ccp_pkg::OFF_PWM_PERIOD[4:2]: s_axi_rdata[7:0] <= pwm_period_register_q;
                    ccp_pkg::OFF_PERIOD_CONTROL[4:2]: s_axi_rdata[7:0] <= period_timer_control_q;
                    ccp_pkg::OFF_PERIOD_COUNT[4:2]: s_axi_rdata[7:0] <= period_timer_count_q;
                    ccp_pkg::OFF_ALT_PIN_SELECT[4:2]: s_axi_rdata[0] <= alternate_pin_select_q;
                    ccp_pkg::OFF_STATUS[4:2]: s_axi_rdata[ccp_pkg::STAT_FLAG_BIT] <= unit_interrupt_flag_q;
                endcase
            end
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Mode decode
    always_comb begin
        mode_field = unit_control_q[ccp_pkg::MODE_LSB +: 4];
        pwm_mode = (mode_field[3:2] == ccp_pkg::MODE_PWM_TOP);
        cmp_mode = mode_field inside {ccp_pkg::MODE_TOGGLE, ccp_pkg::MODE_SET_ON_MATCH,
            ccp_pkg::MODE_CLEAR_ON_MATCH, ccp_pkg::MODE_SOFT_INT, ccp_pkg::MODE_SPECIAL_EVENT};
        // Soft interrupt and special event modes never own the pin
        pin_driven = pwm_mode || (mode_field inside {ccp_pkg::MODE_TOGGLE,
            ccp_pkg::MODE_SET_ON_MATCH, ccp_pkg::MODE_CLEAR_ON_MATCH});
        // Timer from an external clock must be synchronised upstream
        match_now = cmp_mode && !sleep_mode
            && (timer_count == {compare_value_high_q, compare_value_low_q});
        match_rise = match_now && !match_q;
    end

    // Plain control registers; with the period count and high compare byte these shape the PWM
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unit_control_q <= ccp_pkg::RST_BYTE;
            compare_value_low_q <= ccp_pkg::RST_BYTE;
            pwm_period_register_q <= ccp_pkg::RST_PERIOD;
            period_timer_control_q <= ccp_pkg::RST_BYTE;
            alternate_pin_select_q <= 1'b0;
        end else begin
            if (wr_to(ccp_pkg::OFF_UNIT_CONTROL)) begin
                unit_control_q <= w_data_q;
            end
            if (wr_to(ccp_pkg::OFF_COMPARE_LOW)) begin
                compare_value_low_q <= w_data_q;
            end
            if (wr_to(ccp_pkg::OFF_PWM_PERIOD)) begin
                pwm_period_register_q <= w_data_q;
            end
            if (wr_to(ccp_pkg::OFF_PERIOD_CONTROL)) begin
                period_timer_control_q <= {5'h00, w_data_q[2:0]};
            end
            if (wr_to(ccp_pkg::OFF_ALT_PIN_SELECT)) begin
                alternate_pin_select_q <= w_data_q[0];
            end
        end
    end

    // Period timer prescaler and the two time base fraction bits
    always_comb begin
        unique case (period_timer_control_q[ccp_pkg::PT_PRESC_LSB +: 2])
            ccp_pkg::PRESC_DIV1: begin
                presc_top = ccp_pkg::PRESC_TOP_DIV1;
                frac = presc_q[1:0];
            end
            ccp_pkg::PRESC_DIV4: begin
                presc_top = ccp_pkg::PRESC_TOP_DIV4;
                frac = presc_q[3:2];
            end
            default: begin
                presc_top = ccp_pkg::PRESC_TOP_DIV16;
                frac = presc_q[5:4];
            end
        endcase
        pt_inc = period_timer_control_q[ccp_pkg::PT_ON_BIT] && !sleep_mode && (presc_q >= presc_top);
        rollover = pt_inc && (period_timer_count_q == pwm_period_register_q);
    end

    // Prescaler and 8-bit period timer; frozen in sleep
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_q <= ccp_pkg::RST_PRESC;
            period_timer_count_q <= ccp_pkg::RST_BYTE;
        end else if (wr_to(ccp_pkg::OFF_PERIOD_COUNT)) begin
            presc_q <= ccp_pkg::RST_PRESC;
            period_timer_count_q <= w_data_q;
        end else if (period_timer_control_q[ccp_pkg::PT_ON_BIT] && !sleep_mode) begin
            presc_q <= pt_inc ? ccp_pkg::RST_PRESC : presc_q + 6'h01;
            if (rollover) begin
                period_timer_count_q <= ccp_pkg::RST_BYTE;
            end else if (pt_inc) begin
                period_timer_count_q <= period_timer_count_q + 8'h01;
            end
        end
    end

    // High compare byte doubles as the buffered duty, read-only in PWM
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_value_high_q <= ccp_pkg::RST_BYTE;
            duty_latch_q <= 2'h0;
        end else if (pwm_mode) begin
            if (rollover) begin
                compare_value_high_q <= compare_value_low_q;
                duty_latch_q <= unit_control_q[ccp_pkg::DUTY_LOW_LSB +: 2];
            end
        end else if (wr_to(ccp_pkg::OFF_COMPARE_HIGH)) begin
            compare_value_high_q <= w_data_q;
        end
    end

    // PWM level; set one clock after rollover so the high time equals the duty
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rolled_q <= 1'b0;
            pwm_q <= 1'b0;
        end else begin
            rolled_q <= rollover;
            if (!pwm_mode) begin
                pwm_q <= 1'b0;
            end else if (rolled_q) begin
                pwm_q <= ({compare_value_high_q, duty_latch_q} != ccp_pkg::RST_DUTY);
            end else if ({period_timer_count_q, frac} == {compare_value_high_q, duty_latch_q}) begin
                pwm_q <= 1'b0;
            end
        end
    end

    // Compare latch; a control write wins over a match in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_latch_q <= 1'b0;
        end else if (wr_to(ccp_pkg::OFF_UNIT_CONTROL)) begin
            if (w_data_q == ccp_pkg::RST_BYTE) begin
                cmp_latch_q <= 1'b0;
            end else if (w_data_q[3:0] == ccp_pkg::MODE_SET_ON_MATCH) begin
                cmp_latch_q <= 1'b0;
            end else if (w_data_q[3:0] == ccp_pkg::MODE_CLEAR_ON_MATCH) begin
                cmp_latch_q <= 1'b1;
            end
        end else if (match_rise) begin
            if (mode_field == ccp_pkg::MODE_TOGGLE) begin
                cmp_latch_q <= !cmp_latch_q;
            end else if (mode_field == ccp_pkg::MODE_SET_ON_MATCH) begin
                cmp_latch_q <= 1'b1;
            end else if (mode_field == ccp_pkg::MODE_CLEAR_ON_MATCH) begin
                cmp_latch_q <= 1'b0;
            end
        end
    end

    // Unit flag; a new match beats a clearing write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_q <= 1'b0;
            unit_interrupt_flag_q <= 1'b0;
        end else begin
            match_q <= match_now;
            if (match_rise) begin
                unit_interrupt_flag_q <= 1'b1;
            end else if (wr_to(ccp_pkg::OFF_STATUS) && w_data_q[ccp_pkg::STAT_FLAG_BIT]) begin
                unit_interrupt_flag_q <= 1'b0;
            end
        end
    end

    // Special event: trigger and ADC start pulse, then timer clear pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            special_trigger_q <= 1'b0;
            adc_start_q <= 1'b0;
        end else begin
            special_trigger_q <= match_rise && (mode_field == ccp_pkg::MODE_SPECIAL_EVENT);
            adc_start_q <= match_rise && (mode_field == ccp_pkg::MODE_SPECIAL_EVENT) && adc_enable;
        end
    end

    // Tick in the match cycle itself is ignored; clear waits for the next one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= 1'b0;
            timer_clear_q <= 1'b0;
        end else begin
            timer_clear_q <= 1'b0;
            if (mode_field != ccp_pkg::MODE_SPECIAL_EVENT) begin
                pend_q <= 1'b0;
            end else if (match_rise) begin
                pend_q <= 1'b1;
            end else if (pend_q && timer_tick && !sleep_mode) begin
                pend_q <= 1'b0;
                // Separate from overflow, so the timer flag stays untouched
                timer_clear_q <= match_now;
            end
        end
    end

    // Pin routing; direction bit outside gates the real driver
    always_ff @(posedge aclk) begin
        unit_output_pin_o <= '0;
        unit_output_pin_oe <= '0;
        if (aresetn) begin
            unit_output_pin_o[alternate_pin_select_q] <= pwm_mode ? pwm_q : (pin_driven && cmp_latch_q);
            unit_output_pin_oe[alternate_pin_select_q] <= pin_driven;
        end
    end
endmodule : ccp_compare_pwm

/* File: sim/ccp_timer_model.sv */
// Behavioural 16-bit timer standing on the far side of the unit
module ccp_timer_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic restart,
    input wire logic [7:0] tick_div,
    input wire logic timer_clear_q,
    output logic [15:0] timer_count,
    output logic timer_tick
);
    logic [7:0] div_q;

    // One tick every tick_div clocks
    always_ff @(posedge aclk) begin
        if (!aresetn || restart || div_q + 8'h01 >= tick_div) div_q <= 8'h00;
        else div_q <= div_q + 8'h01;
    end
    assign timer_tick = aresetn && !restart && div_q == 8'h00;

    // Clear request zeroes the count and is never treated as a wrap
    always_ff @(posedge aclk) begin
        if (!aresetn || restart || timer_clear_q) timer_count <= 16'h0000;
        else if (timer_tick) timer_count <= timer_count + 16'h0001;
    end
endmodule : ccp_timer_model

/* File: sim/ccp_compare_pwm_chk.sv */
// Concurrent checks on the ports of the compare and PWM unit
module ccp_compare_pwm_chk #(
    parameter int PIN_COUNT = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic timer_tick,
    input wire logic adc_enable,
    input wire logic sleep_mode,
    input wire logic [PIN_COUNT-1:0] unit_output_pin_oe,
    input wire logic special_trigger_q,
    input wire logic adc_start_q,
    input wire logic timer_clear_q,
    input wire logic unit_interrupt_flag_q
);
    // Single domain, so one clock and one reset serve every check
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_adc_with_trig: assert property (adc_start_q |-> special_trigger_q && $past(adc_enable))
        else $error("conversion start without trigger or enable");
    chk_adc_one_cycle: assert property (adc_start_q |=> !adc_start_q)
        else $error("conversion start longer than one cycle");
    chk_trig_one_cycle: assert property (special_trigger_q |=> !special_trigger_q)
        else $error("trigger longer than one cycle");
    chk_trig_sets_flag: assert property (special_trigger_q |-> unit_interrupt_flag_q)
        else $error("trigger without unit flag");
    chk_trig_pin_free: assert property (special_trigger_q |-> unit_output_pin_oe == '0)
        else $error("pin owned in trigger mode");
    chk_clear_after_tick: assert property (timer_clear_q |-> $past(timer_tick) && !special_trigger_q)
        else $error("timer clear not one edge after a later tick");
    chk_clear_one_cycle: assert property (timer_clear_q |=> !timer_clear_q)
        else $error("timer clear longer than one cycle");
    chk_sleep_quiet: assert property (sleep_mode |=> !special_trigger_q && !adc_start_q)
        else $error("match acted on during sleep");
    chk_one_pin_owned: assert property ($countones(unit_output_pin_oe) <= 1)
        else $error("more than one pin location driven");
endmodule : ccp_compare_pwm_chk

bind ccp_compare_pwm ccp_compare_pwm_chk #(.PIN_COUNT(PIN_COUNT)) u_chk (.aclk, .aresetn, .timer_tick,
    .adc_enable, .sleep_mode, .unit_output_pin_oe, .special_trigger_q, .adc_start_q, .timer_clear_q,
    .unit_interrupt_flag_q);

/* File: sim/ccp_compare_pwm_tb_top.sv */
// Self-checking bench for the compare and PWM unit
module ccp_compare_pwm_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIMIT = 40000;
    localparam logic [7:0] RW_OFF [3] = '{ccp_pkg::OFF_COMPARE_LOW, ccp_pkg::OFF_COMPARE_HIGH, ccp_pkg::OFF_PWM_PERIOD};
    localparam logic [3:0] OUT_MODES [3] = '{ccp_pkg::MODE_SET_ON_MATCH, ccp_pkg::MODE_CLEAR_ON_MATCH, 4'h2};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic restart = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, tick_div = 8'h02;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic adc_enable = 1'b0, sleep_mode = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, trig, adc, clr, flag, tick;
    logic [1:0] bresp, rresp, rr, pin_o, pin_oe;
    logic [15:0] tcount;
    logic [31:0] rdata, rd;
    int bad_count = 0, compares = 0, cycles = 0, n_trig = 0, n_adc = 0, n_clr = 0, n_hi = 0;
    int i, s, t, t0, a0, c0, cval, dv, p, d, mul;

    ccp_compare_pwm dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_count(tcount),
        .timer_tick(tick), .adc_enable, .sleep_mode, .unit_output_pin_o(pin_o),
        .unit_output_pin_oe(pin_oe), .special_trigger_q(trig), .adc_start_q(adc), .timer_clear_q(clr),
        .unit_interrupt_flag_q(flag));
    ccp_timer_model u_timer (.aclk, .aresetn, .restart, .tick_div, .timer_clear_q(clr), .timer_count(tcount),
        .timer_tick(tick));

    initial begin
        forever #25 aclk = ~aclk;
    end

    // Event tallies and hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (trig === 1'b1) n_trig <= n_trig + 1;
        if (adc === 1'b1) n_adc <= n_adc + 1;
        if (clr === 1'b1) n_clr <= n_clr + 1;
        if (pin_o[0] === 1'b1) n_hi <= n_hi + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            summarize();
        end
    end

    function automatic logic [31:0] latch_exp(input logic [3:0] m);
        return (m == ccp_pkg::MODE_CLEAR_ON_MATCH) ? 32'h00000000 : 32'h00000001;
    endfunction : latch_exp

    // Duty at or beyond the period keeps the pin high all period
    function automatic int pwm_high(input int p, input int d, input int mul, input int k);
        return k * mul * ((d < 4 * (p + 1)) ? d : 4 * (p + 1));
    endfunction : pwm_high

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // Address and data offered together
    task automatic axi_wr(input logic [7:0] a, input int v, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, v[7:0]};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        r = bresp;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        dt = rdata;
        r = rresp;
    endtask : axi_rd

    task automatic wr(input logic [7:0] a, input int v);
        logic [1:0] r;
        axi_wr(a, v, r);
        check(32'(r), 32'(ccp_pkg::RESP_OKAY));
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input int v);
        axi_rd(a, rd, rr);
        check(rd, 32'(v));
    endtask : rdchk

    // Timer held at zero during set-up
    task automatic arm(input logic [3:0] m, input int cv, input int div);
        restart <= 1'b1;
        wr(ccp_pkg::OFF_UNIT_CONTROL, 0);
        wr(ccp_pkg::OFF_COMPARE_HIGH, 0);
        wr(ccp_pkg::OFF_COMPARE_LOW, cv);
        tick_div <= 8'(div);
        wr(ccp_pkg::OFF_UNIT_CONTROL, int'(m));
        restart <= 1'b0;
    endtask : arm

    task automatic wait_trig(output int n);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (trig !== 1'b1 && n < 2000);
    endtask : wait_trig

    initial begin
        void'($urandom(32'hE1BA9457));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (i = 0; i < 8; i++) rdchk(8'(i * 4), (i == 3) ? ccp_pkg::RST_PERIOD : ccp_pkg::RST_BYTE);
        axi_rd(8'h20, rd, rr);
        check(32'(rr), 32'(ccp_pkg::RESP_SLVERR));
        axi_wr(8'h24, 8'h5A, rr);
        check(32'(rr), 32'(ccp_pkg::RESP_SLVERR));
        for (i = 0; i < 6; i++) begin
            d = $urandom_range(255);
            wr(RW_OFF[i % 3], d);
            rdchk(RW_OFF[i % 3], d);
        end
        // Output modes on a random pin location, then a zero control write
        for (i = 0; i < 3; i++) begin
            s = $urandom_range(1);
            wr(ccp_pkg::OFF_ALT_PIN_SELECT, s);
            arm(OUT_MODES[i], $urandom_range(4, 30), 2);
            repeat (100) @(posedge aclk);
            check(32'(pin_oe), 32'(2'b01 << s));
            check(32'(pin_o[s]), latch_exp(OUT_MODES[i]));
            rdchk(ccp_pkg::OFF_STATUS, 1);
            wr(ccp_pkg::OFF_STATUS, 1);
            wr(ccp_pkg::OFF_UNIT_CONTROL, 0);
            repeat (3) @(posedge aclk);
            check(32'(pin_oe), 0);
            check(32'(pin_o[s]), 0);
        end
        arm(ccp_pkg::MODE_SOFT_INT, 16, 2);
        t0 = n_trig;
        repeat (80) @(posedge aclk);
        check(32'(pin_oe), 0);
        check(32'(n_trig - t0), 0);
        rdchk(ccp_pkg::OFF_STATUS, 1);
        wr(ccp_pkg::OFF_STATUS, 1);
        rdchk(ccp_pkg::OFF_STATUS, 0);
        // Special event: period, conversion start, timer clear
        cval = $urandom_range(4, 40);
        dv = $urandom_range(2, 4);
        adc_enable <= 1'b1;
        arm(ccp_pkg::MODE_SPECIAL_EVENT, cval, dv);
        t0 = n_trig;
        a0 = n_adc;
        c0 = n_clr;
        for (i = 0; i < 3; i++) begin
            wait_trig(t);
            check(32'(pin_oe), 0);
        end
        check(32'(t), 32'((cval + 1) * dv));
        repeat (dv + 4) @(posedge aclk);
        check(32'(n_trig - t0), 3);
        check(32'(n_adc - a0), 3);
        check(32'(n_clr - c0), 3);
        adc_enable <= 1'b0;
        a0 = n_adc;
        wait_trig(t);
        repeat (2) @(posedge aclk);
        check(32'(n_adc - a0), 0);
        // Slow ticks leave room to move the compare value before the clear
        tick_div <= 8'h10;
        wait_trig(t);
        wait_trig(t);
        c0 = n_clr;
        wr(ccp_pkg::OFF_COMPARE_LOW, cval ^ 8'h80);
        repeat (40) @(posedge aclk);
        check(32'(n_clr - c0), 0);
        sleep_mode <= 1'b1;
        arm(ccp_pkg::MODE_SPECIAL_EVENT, 8, 2);
        t0 = n_trig;
        repeat (60) @(posedge aclk);
        check(32'(n_trig - t0), 0);
        sleep_mode <= 1'b0;
        wr(ccp_pkg::OFF_UNIT_CONTROL, 0);
        wr(ccp_pkg::OFF_ALT_PIN_SELECT, 0);
        // PWM: zero duty, full duty, random duty, then a slower prescale
        for (i = 0; i < 4; i++) begin
            p = $urandom_range(2, 15);
            d = (i == 0) ? 0 : (i == 1) ? 4 * (p + 1) : $urandom_range(1, 4 * p + 3);
            mul = (i == 3) ? 4 : 1;
            wr(ccp_pkg::OFF_PERIOD_CONTROL, 0);
            wr(ccp_pkg::OFF_PERIOD_COUNT, 0);
            wr(ccp_pkg::OFF_PWM_PERIOD, p);
            wr(ccp_pkg::OFF_COMPARE_LOW, d >> 2);
            wr(ccp_pkg::OFF_UNIT_CONTROL, 12 + 16 * (d % 4));
            wr(ccp_pkg::OFF_PERIOD_CONTROL, (i == 3) ? 5 : 4);
            repeat (8 * mul * (p + 1) + 8) @(posedge aclk);
            t = n_hi;
            repeat (12 * mul * (p + 1)) @(posedge aclk);
            check(32'(pin_oe), 1);
            check(32'(n_hi - t), 32'(pwm_high(p, d, mul, 3)));
        end
        wr(ccp_pkg::OFF_UNIT_CONTROL, 0);
        repeat (3) @(posedge aclk);
        check(32'(pin_oe), 0);
        summarize();
    end
endmodule : ccp_compare_pwm_tb_top
